// ### logic/can_tx_regs.svh
// Register offsets, field positions and reset values of the transmit buffer
// bookkeeping block. Byte addresses on a 32-bit Avalon-MM slave.
`ifndef CAN_TX_REGS_SVH
`define CAN_TX_REGS_SVH

`define TXR_NUM_BUF 3
`define TXR_ADDR_W 5

`define TXR_OFF_EMPTY 5'h00
`define TXR_OFF_IRQ_EN 5'h04
`define TXR_OFF_ABORT_RQ 5'h08
`define TXR_OFF_ABORT_AK 5'h0c
`define TXR_OFF_CTRL 5'h10
`define TXR_OFF_STATUS 5'h14
`define TXR_OFF_EVENTS 5'h18
`define TXR_OFF_EVENT_MASK 5'h1c

`define TXR_CTRL_INIT_RQ 0
`define TXR_CTRL_LISTEN 1
`define TXR_STATUS_INIT_AK 0
`define TXR_EV_SENT_LSB 0
`define TXR_EV_ABORT_LSB 3
`define TXR_EV_W 6

`define TXR_RST_EMPTY 3'h7
`define TXR_RST_IRQ_EN 3'h0
`define TXR_RST_ABORT_RQ 3'h0
`define TXR_RST_ABORT_AK 3'h0
`define TXR_RST_CTRL 2'h0
`define TXR_RST_EVENTS 6'h00

`endif

// ### logic/can_tx_pkg.sv
// Types shared by the transmit buffer bookkeeping block.
// Assumes the constants header is included alongside.
package can_tx_pkg;

	typedef logic [2:0] buf_mask_t;

	// Bus answer phase: wait one cycle, then answer
	typedef enum logic [0:0] {
		bus_wait = 1'b0,
		bus_answer = 1'b1
	} bus_phase_e;

endpackage : can_tx_pkg

// ### logic/can_tx_buffer_abort_control.sv
// Transmit buffer empty, interrupt enable, abort request and abort
// acknowledge bookkeeping for three CAN transmit buffers.
// Assumes the transmit engine runs on the same clock as the bus slave.
//
// Functional notes
// - Empty flag per buffer, 1 means empty
// - Successful send sets the empty flag
// - Granted abort sets the empty flag
// - Empty and enabled holds transmit interrupt
// - Clearing empty flag clears abort acknowledge
// - Empty flag set clears abort request
// - Listen-only blocks flag clears and starts
// - Block buffer access while scheduled
// - Init mode holds the four buffer flag registers in reset
// - Buffer register writes accepted only outside init mode
// - Per-buffer enable gates empty interrupt
// - Grant abort if unstarted or failed
// - Abort sets empty and acknowledge flags
// - Writing zero never clears abort request
// - Acknowledge tells aborted from sent
// - Empty flag is write-one-to-clear
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "can_tx_regs.svh"

module can_tx_buffer_abort_control
	import can_tx_pkg::*;
#(
	parameter int NUM_BUF = `TXR_NUM_BUF
) (
	input wire logic clock,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [`TXR_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Transmit engine
	output logic [NUM_BUF-1:0] tx_pending,
	output logic [NUM_BUF-1:0] tx_abort_pending,
	input wire logic [NUM_BUF-1:0] tx_busy,
	input wire logic [NUM_BUF-1:0] tx_done,
	input wire logic [NUM_BUF-1:0] tx_fail,
	// Message buffer access gate and interrupts
	output logic [NUM_BUF-1:0] buf_access_allow,
	output logic [NUM_BUF-1:0] tx_empty_irq,
	output logic irq
);

	// ***************************************
	// Bus slave
	// ***************************************

	bus_phase_e phase;
	logic [NUM_BUF-1:0] tx_buffer_empty_flag;
	logic [NUM_BUF-1:0] tx_empty_irq_enable;
	logic [NUM_BUF-1:0] abort_request_bit;
	logic [NUM_BUF-1:0] abort_acknowledge_flag;
	logic init_mode_request;
	logic init_mode_acknowledge;
	logic listen_only;
	logic [`TXR_EV_W-1:0] events;
	logic [`TXR_EV_W-1:0] event_mask;

	logic access;
	logic wr_take;
	logic rd_take;
	logic init_active;
	logic wr_open;
	logic [7:0] wbyte;

	assign access = read | write;
	assign waitrequest = access & (phase == bus_wait);
	assign wr_take = write & (phase == bus_answer) & byteenable[0];
	assign rd_take = read & (phase == bus_wait);
	assign wbyte = writedata[7:0];
	assign init_active = init_mode_request & init_mode_acknowledge;
	assign wr_open = ~init_mode_request & ~init_mode_acknowledge;

	function automatic logic hit(input logic [`TXR_ADDR_W-1:0] off);
		hit = (address == off);
	endfunction : hit

	// Every access waits exactly one cycle, so no address is left hanging
	always_ff @(posedge clock) begin
		if (!nrst) begin
			phase <= bus_wait;
		end else if (access && phase == bus_wait) begin
			phase <= bus_answer;
		end else begin
			phase <= bus_wait;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			readdata <= 32'h0000_0000;
		end else if (rd_take) begin
			readdata <= 32'h0000_0000;
			unique case (address)
				`TXR_OFF_EMPTY: readdata[NUM_BUF-1:0] <= tx_buffer_empty_flag;
				`TXR_OFF_IRQ_EN: readdata[NUM_BUF-1:0] <= tx_empty_irq_enable;
				`TXR_OFF_ABORT_RQ: readdata[NUM_BUF-1:0] <= abort_request_bit;
				`TXR_OFF_ABORT_AK: readdata[NUM_BUF-1:0] <= abort_acknowledge_flag;
				`TXR_OFF_CTRL: begin
					readdata[`TXR_CTRL_INIT_RQ] <= init_mode_request;
					readdata[`TXR_CTRL_LISTEN] <= listen_only;
				end
				`TXR_OFF_STATUS: readdata[`TXR_STATUS_INIT_AK] <= init_mode_acknowledge;
				`TXR_OFF_EVENTS: readdata[`TXR_EV_W-1:0] <= events;
				`TXR_OFF_EVENT_MASK: readdata[`TXR_EV_W-1:0] <= event_mask;
				default: readdata <= 32'h0000_0000;
			endcase
		end
	end

	// ***************************************
	// Mode control
	// ***************************************

	always_ff @(posedge clock) begin
		if (!nrst) begin
			init_mode_request <= 1'b0;
			listen_only <= 1'b0;
		end else if (wr_take && hit(`TXR_OFF_CTRL)) begin
			init_mode_request <= wbyte[`TXR_CTRL_INIT_RQ];
			listen_only <= wbyte[`TXR_CTRL_LISTEN];
		end
	end

	// Acknowledge trails the request by one cycle, both ways
	always_ff @(posedge clock) begin
		if (!nrst) begin
			init_mode_acknowledge <= 1'b0;
		end else begin
			init_mode_acknowledge <= init_mode_request;
		end
	end

	// ***************************************
	// Buffer flags
	// ***************************************

	logic [NUM_BUF-1:0] sw_clear;
	logic [NUM_BUF-1:0] sw_abort;
	logic [NUM_BUF-1:0] grant;
	logic [NUM_BUF-1:0] sent;
	logic [NUM_BUF-1:0] next_empty;

	assign sw_clear = (wr_take && wr_open && !listen_only && hit(`TXR_OFF_EMPTY))
		? wbyte[NUM_BUF-1:0] : '0;
	assign sw_abort = (wr_take && wr_open && hit(`TXR_OFF_ABORT_RQ))
		? wbyte[NUM_BUF-1:0] : '0;

	assign sent = tx_done & ~tx_buffer_empty_flag;
	// abort only unstarted or failed
	// A success in the same cycle wins, so the acknowledge stays low
	assign grant = abort_request_bit & ~tx_buffer_empty_flag & ~tx_done
		& (~tx_busy | tx_fail);

	// grant sets empty
	// Hardware set wins over a software clear in the same cycle
	assign next_empty = (tx_buffer_empty_flag & ~sw_clear) | sent | grant;

	always_ff @(posedge clock) begin
		if (!nrst || init_active) begin
			tx_buffer_empty_flag <= `TXR_RST_EMPTY;
		end else begin
			tx_buffer_empty_flag <= next_empty;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst || init_active) begin
			tx_empty_irq_enable <= `TXR_RST_IRQ_EN;
		end else if (wr_take && wr_open && hit(`TXR_OFF_IRQ_EN)) begin
			tx_empty_irq_enable <= wbyte[NUM_BUF-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst || init_active) begin
			abort_request_bit <= `TXR_RST_ABORT_RQ;
		end else begin
			abort_request_bit <= (abort_request_bit | sw_abort) & ~next_empty;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst || init_active) begin
			abort_acknowledge_flag <= `TXR_RST_ABORT_AK;
		end else begin
			abort_acknowledge_flag <= grant
				| (abort_acknowledge_flag & ~(tx_buffer_empty_flag & ~next_empty));
		end
	end

	// ***************************************
	// Engine and buffer access
	// ***************************************

	assign tx_pending = listen_only ? '0 : ~tx_buffer_empty_flag;
	assign tx_abort_pending = abort_request_bit;
	assign buf_access_allow = tx_buffer_empty_flag;

	// ***************************************
	// Interrupts
	// ***************************************

	assign tx_empty_irq = tx_buffer_empty_flag & tx_empty_irq_enable;

	logic [`TXR_EV_W-1:0] ev_set;
	logic [`TXR_EV_W-1:0] ev_clr;

	assign ev_set = {grant, sent};
	assign ev_clr = (wr_take && hit(`TXR_OFF_EVENTS)) ? wbyte[`TXR_EV_W-1:0] : '0;

	// Sticky events; a set in the clear cycle survives
	always_ff @(posedge clock) begin
		if (!nrst) begin
			events <= `TXR_RST_EVENTS;
		end else begin
			events <= (events & ~ev_clr) | ev_set;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			event_mask <= `TXR_RST_EVENTS;
		end else if (wr_take && hit(`TXR_OFF_EVENT_MASK)) begin
			event_mask <= wbyte[`TXR_EV_W-1:0];
		end
	end

	assign irq = |(events & event_mask);

	// ***************************************
	// Assertions
	// ***************************************

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	a_send_sets_empty: assert property (
		(tx_done & ~tx_buffer_empty_flag) != 0 && !init_active
		|=> (tx_buffer_empty_flag & $past(tx_done)) == $past(tx_done & ~tx_buffer_empty_flag)
	) else $error("successful send did not set empty flag");

	a_abort_sets_flags: assert property (
		grant != 0 && !init_active
		|=> ((tx_buffer_empty_flag & abort_acknowledge_flag & $past(grant)) == $past(grant))
	) else $error("granted abort did not set empty and acknowledge");

	a_grant_condition: assert property (
		(grant & tx_busy & ~tx_fail) == 0
	) else $error("abort granted during running transmission");

	a_request_clears: assert property (
		!$past(init_active) |-> (abort_request_bit & tx_buffer_empty_flag) == 0
	) else $error("abort request survives empty flag");

	a_clear_drops_ack: assert property (
		(tx_buffer_empty_flag & ~next_empty) != 0
		|=> (abort_acknowledge_flag & $past(tx_buffer_empty_flag & ~next_empty)) == 0
	) else $error("acknowledge kept after empty cleared");

	a_listen_blocks: assert property (
		listen_only |-> tx_pending == 0 && sw_clear == 0
	) else $error("listen-only started or cleared a buffer");

	a_init_holds: assert property (
		init_active ##1 init_active |-> tx_buffer_empty_flag == `TXR_RST_EMPTY
		&& tx_empty_irq_enable == 0 && abort_request_bit == 0 && abort_acknowledge_flag == 0
	) else $error("registers not held during init");

	a_init_write_refused: assert property (
		wr_take && !wr_open && hit(`TXR_OFF_IRQ_EN)
		|=> (tx_empty_irq_enable & ~$past(tx_empty_irq_enable)) == 0
	) else $error("enable written in init mode");

	a_irq_level: assert property (
		tx_empty_irq == (tx_buffer_empty_flag & tx_empty_irq_enable)
		&& irq == |(events & event_mask)
	) else $error("interrupt level mismatch");

	a_bus_answer: assert property (
		$rose(access) |-> waitrequest ##1 !waitrequest
	) else $error("bus answer not after one wait cycle");

	a_init_ack_follows: assert property (
		init_mode_acknowledge == $past(init_mode_request)
	) else $error("init acknowledge does not trail request");

	// ***************************************
	// Register side checks
	// ***************************************

	// Bits already empty cannot be set again by the engine, so they must drop
	a_empty_w1c: assert property (
		(sw_clear & tx_buffer_empty_flag) != 0 && !init_active
		|=> (tx_buffer_empty_flag & $past(sw_clear & tx_buffer_empty_flag)) == 0
	) else $error("write of one did not clear empty flag");

	a_listen_clear_refused: assert property (
		listen_only && wr_take && hit(`TXR_OFF_EMPTY)
		|=> (~tx_buffer_empty_flag & $past(tx_buffer_empty_flag)) == 0
	) else $error("empty flag cleared in listen-only");

	// Only a set empty flag may drop a pending request
	a_abort_rq_held: assert property (
		!init_active |=> ($past(abort_request_bit) & ~abort_request_bit
		& ~tx_buffer_empty_flag) == 0
	) else $error("abort request dropped without empty flag");

	// Host writes to the acknowledge register must not show up
	a_ack_only_grant: assert property (
		!init_active
		|=> (abort_acknowledge_flag & ~$past(abort_acknowledge_flag | grant)) == 0
	) else $error("acknowledge set without granted abort");

	// Ack is low while empty is low, so a send must leave it clear
	a_send_beats_abort: assert property (
		(tx_done & ~tx_buffer_empty_flag & abort_request_bit) != 0 && !init_active
		|=> (abort_acknowledge_flag & $past(tx_done & ~tx_buffer_empty_flag)) == 0
	) else $error("acknowledge set for a sent message");

	a_grant_needs_request: assert property (
		(grant & ~abort_request_bit) == 0
	) else $error("abort granted without request");

	a_enable_write_lands: assert property (
		wr_take && wr_open && hit(`TXR_OFF_IRQ_EN)
		|=> tx_empty_irq_enable == $past(wbyte[NUM_BUF-1:0])
	) else $error("enable write outside init mode lost");

	a_access_gate: assert property (
		(buf_access_allow & ~tx_buffer_empty_flag) == 0
	) else $error("scheduled buffer left open to host");

	a_read_upper_zero: assert property (
		rd_take && address <= `TXR_OFF_ABORT_AK |=> readdata[31:NUM_BUF] == '0
	) else $error("unused register bits read nonzero");

	// Set wins over a clear in the same cycle
	a_events_sticky: assert property (
		ev_set != 0 |=> (events & $past(ev_set)) == $past(ev_set)
	) else $error("event bit lost in the cycle it was set");

endmodule : can_tx_buffer_abort_control

// ### dv/can_bus_engine_model.sv
// Behavioural transmit engine standing on the CAN side of the block.
// Assumes the bench steers each buffer through run and fail_sel.
`timescale 1ns/1ps
module can_bus_engine_model (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [2:0] tx_pending,
	input wire logic [2:0] run,
	input wire logic [2:0] fail_sel,
	output logic [2:0] tx_busy,
	output logic [2:0] tx_done,
	output logic [2:0] tx_fail
);
	// ****************************************
	// Engine per buffer
	// ****************************************
	// Busy only while scheduled, so a withdrawn buffer never ends in a pulse
	always_ff @(posedge clock) begin
		for (int i = 0; i < 3; i++) begin
			tx_done[i] <= 1'b0;
			tx_fail[i] <= 1'b0;
			if (!nrst || !tx_pending[i]) begin
				tx_busy[i] <= 1'b0;
			end else if (tx_busy[i] && !run[i]) begin
				tx_busy[i] <= 1'b0;
				tx_done[i] <= !fail_sel[i];
				tx_fail[i] <= fail_sel[i];
			end else if (run[i]) begin
				tx_busy[i] <= 1'b1;
			end
		end
	end
endmodule : can_bus_engine_model

// ### dv/tb_top.sv
// Self-checking bench for the transmit buffer bookkeeping block.
// Assumes the design, its package and the engine model are compiled first.
`timescale 1ns/1ps
module tb_top;
	logic clock, nrst, read, write, waitrequest, irq, e_ls;
	logic [4:0] address;
	logic [31:0] writedata, readdata, q, seed;
	logic [3:0] byteenable;
	logic [2:0] tx_pending, tx_abort_pending, tx_busy, tx_done, tx_fail;
	logic [2:0] buf_access_allow, tx_empty_irq, run, fail_sel;
	logic [7:0] e_em, e_ie, e_aq, e_ak, e_ev, e_mk;
	int errors, n_compared, cycles;

	can_tx_buffer_abort_control dut (.clock, .nrst, .address, .read, .write, .writedata,
		.byteenable, .readdata, .waitrequest, .tx_pending, .tx_abort_pending, .tx_busy,
		.tx_done, .tx_fail, .buf_access_allow, .tx_empty_irq, .irq);
	can_bus_engine_model engine (.clock, .nrst, .tx_pending, .run, .fail_sel, .tx_busy,
		.tx_done, .tx_fail);

	// ****************************************
	// Tasks
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clock);
		address <= a;
		writedata <= {seed[31:8], d};
		write <= w;
		read <= !w;
		// Only the bench timeout ends a wait that never answers
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	task automatic cmp_reg(input logic [4:0] a, input string nm, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		n_compared++;
		if (q !== {24'h0, e}) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, q);
		end
	endtask : cmp_reg

	task automatic cmp_pin(input string nm, input logic [2:0] e, input logic [2:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_pin

	task automatic check_all;
		cmp_reg(5'h00, "empty", e_em);
		cmp_reg(5'h04, "irq_en", e_ie);
		cmp_reg(5'h08, "abort_rq", e_aq);
		cmp_reg(5'h0c, "abort_ak", e_ak);
		cmp_reg(5'h18, "events", e_ev);
		cmp_pin("pending", ~e_em[2:0] & {3{!e_ls}}, tx_pending);
		cmp_pin("access", e_em[2:0], buf_access_allow);
		cmp_pin("tx_irq", e_em[2:0] & e_ie[2:0], tx_empty_irq);
		cmp_pin("irq", {2'b0, |(e_ev & e_mk)}, {2'b0, irq});
		cmp_pin("abort_pend", e_aq[2:0], tx_abort_pending);
	endtask : check_all

	task automatic final_report;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	// ****************************************
	// Clock, timeout and sequence
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			final_report;
		end
	end

	initial begin
		{nrst, read, write, address, writedata, run, fail_sel, e_ls} = '0;
		byteenable = 4'hf;
		seed = 32'h6c9f;
		{e_em, e_ie, e_aq, e_ak, e_ev, e_mk} = {8'h07, 40'h0};
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		check_all;
		wr(5'h04, 8'hff); e_ie = 8'h07; wr(5'h0c, 8'hff); check_all;
		wr(5'h00, 8'h01); e_em = 8'h06; check_all;
		wr(5'h00, 8'h00); check_all;
		run[0] <= 1'b1; tick(3); run[0] <= 1'b0; tick(3); e_em = 8'h07; e_ev = 8'h01;
		check_all;
		wr(5'h1c, 8'h3f); e_mk = 8'h3f; wr(5'h04, 8'h02); e_ie = 8'h02; check_all;
		wr(5'h00, 8'h02); wr(5'h08, 8'h02); e_ak = 8'h02; e_ev = 8'h11; check_all;
		wr(5'h00, 8'h02); e_em = 8'h05; e_ak = 8'h00; check_all;
		wr(5'h08, 8'h02); e_em = 8'h07; e_ak = 8'h02; check_all;
		wr(5'h00, 8'h04); run[2] <= 1'b1; tick(3); wr(5'h08, 8'h04); wr(5'h08, 8'h00);
		e_em = 8'h03; e_aq = 8'h04; check_all;
		run[2] <= 1'b0; tick(3); e_em = 8'h07; e_aq = 8'h00; e_ev = 8'h15; check_all;
		wr(5'h00, 8'h01); fail_sel[0] <= 1'b1; run[0] <= 1'b1; tick(3); wr(5'h08, 8'h01);
		e_em = 8'h06; e_aq = 8'h01; check_all;
		run[0] <= 1'b0; tick(3); e_em = 8'h07; e_aq = 8'h00; e_ak = 8'h03; e_ev = 8'h1d;
		check_all;
		fail_sel[0] <= 1'b0;
		wr(5'h00, 8'h01); wr(5'h10, 8'h02); e_ls = 1'b1; wr(5'h00, 8'h02);
		e_em = 8'h06; e_ak = 8'h02; check_all;
		wr(5'h10, 8'h00); e_ls = 1'b0; wr(5'h08, 8'h01); e_em = 8'h07; e_ak = 8'h03;
		check_all;
		wr(5'h18, 8'h3f); e_ev = 8'h00; check_all;
		wr(5'h10, 8'h01); tick(2); wr(5'h04, 8'h07); wr(5'h08, 8'h01);
		cmp_reg(5'h14, "init_ack", 8'h01); e_ie = 8'h00; e_ak = 8'h00; check_all;
		wr(5'h10, 8'h00); tick(2); check_all;
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr(5'h04, seed[7:0]);
			cmp_reg(5'h04, "irq_en", {5'h0, seed[2:0]});
		end
		byteenable <= 4'he; wr(5'h04, 8'h05); byteenable <= 4'hf;
		cmp_reg(5'h04, "irq_en", {5'h0, seed[2:0]});
		cmp_reg(5'h02, "unmapped", 8'h00);
		final_report;
	end
endmodule : tb_top
